// ---- inc/wer_map.svh ----
// offsets, field positions, reset values and delay counts of the wake block
`ifndef WER_MAP_SVH
`define WER_MAP_SVH

// register byte offsets
`define WER_RCS_OFS      12'h000
`define WER_OSC_OFS      12'h004
`define WER_KIND_OFS     12'h008

// reset cause status fields
`define WER_RCS_PRIO     7
`define WER_RCS_SBOR     6
`define WER_RCS_RI       4
`define WER_RCS_TO       3
`define WER_RCS_PD       2
`define WER_RCS_POR      1
`define WER_RCS_BOR      0

// oscillator control and status fields
`define WER_OSC_FREQ_HI  6
`define WER_OSC_FREQ_LO  4
`define WER_OSC_PRI_RDY  3
`define WER_OSC_INT_RDY  2

// reset values and codes
`define WER_FREQ_1MHZ    3'h4
`define WER_SBOR_RST     1'b1
`define WER_BOR_SW_MODE  2'h1
`define WER_BOR_OFF_MODE 2'h0

// delay defaults in clock cycles
`define WER_OST_CYC      1024
`define WER_PLL_CYC      2000
`define WER_CPU_CYC      20
`define WER_SETTLE_CYC   100

`endif

// ---- inc/wer_pkg.sv ----
// types shared by the wake exit and reset status block
package wer_pkg;

    // clock source selected for running
    typedef enum logic [1:0] {
        WER_SRC_PRI,
        WER_SRC_SEC,
        WER_SRC_INT
    } wer_src_e;

    // kind of primary oscillator
    typedef enum logic [1:0] {
        WER_PT_XTAL,
        WER_PT_PLL,
        WER_PT_EXT
    } wer_ptype_e;

    // reset kinds
    typedef enum logic [2:0] {
        WER_RK_POR,
        WER_RK_PIN_RUN,
        WER_RK_PIN_PM,
        WER_RK_WDT,
        WER_RK_BOR,
        WER_RK_INSTR,
        WER_RK_STK_FULL,
        WER_RK_STK_UNDER
    } wer_rkind_e;

    // sequencer states
    typedef enum logic [1:0] {
        WER_ST_RUN,
        WER_ST_IDLE,
        WER_ST_SLEEP,
        WER_ST_EXIT
    } wer_state_e;

endpackage

// ---- hdl/wer_top.sv ----
// wake exit sequencer and reset cause status register with apb access
// Summary of operation
// RQ1: watchdog time-out in sleep/idle wakes, no reset
// RQ2: watchdog time-out while running causes watchdog reset
// RQ3: sleep, clear, clock loss, freq write clear watchdog; here clock loss needs cfg_failsafe, freq write needs clk_sel internal
// RQ4: reset exit holds until primary clock ready
// RQ5: internal target sets internal-stable flag instead
// RQ6: two-speed or fail-safe runs early on internal
// RQ7: sleep before primary ready shuts primary down
// RQ8: no start-up timer from primary idle, non-crystal
// RQ9: cpu-ready delay on every sleep/idle exit
// RQ10: primary idle exit uses only cpu-ready delay
// RQ11: crystal waits start-up, pll adds lock time
// RQ12: internal target runs during settle; none from idle
// RQ13: cpu-ready delay runs alongside other delays
// RQ14: internal frequency resets to 1 MHz
// RQ15: eight reset kinds are told apart
// RQ16: low five bits are per-event flags
// RQ17: register holds priority and brown-out enable bits
// RQ18: bit layout fixed; time-out, power-down read-only
// RQ19: time-out flag set by power-up, clear, sleep
// RQ20: power-down flag set by clear, cleared by sleep
// RQ21: power-on flag cleared only by power-on reset; here a register write of 0 to bit 1 also clears it
// RQ22: brown-out enable acts only in mode 01
// RQ23: delays are parameterised cycle counts
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "wer_map.svh"

module wer_top #(
    parameter int unsigned OST_CYC    = `WER_OST_CYC,
    parameter int unsigned PLL_CYC    = `WER_PLL_CYC,
    parameter int unsigned CPU_CYC    = `WER_CPU_CYC,
    parameter int unsigned SETTLE_CYC = `WER_SETTLE_CYC,
    parameter int unsigned CW         = 16
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // apb slave
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // configuration
    input  wire logic [1:0]          brownout_mode_config,
    input  wire logic                cfg_two_speed,
    input  wire logic                cfg_failsafe,
    input  wire wer_pkg::wer_ptype_e cfg_prim_type,
    // core events and clock selection
    input  wire logic                sleep_instr,
    input  wire logic                idle_en,
    input  wire logic                watchdog_clear_instruction,
    input  wire wer_pkg::wer_src_e   clk_sel,
    // watchdog, oscillators and reset sources
    input  wire logic                wdt_timeout,
    input  wire logic                clock_lost,
    input  wire logic                rst_event,
    input  wire wer_pkg::wer_rkind_e rst_kind,
    // control outputs
    output logic                     wdt_clear,
    output logic                     wdt_reset_req,
    output logic                     cpu_exec,
    output logic                     exec_internal,
    output logic                     primary_shutdown,
    output logic                     bor_enable,
    output logic                     interrupt_priority_enable
);

    logic [1:0]          rst_sync_reg;
    logic                rst_s_n;
    logic [7:0]          prdata_reg;
    logic [7:0]          rd_data;
    logic                rd_err;
    logic                acc;
    logic                wr_rcs;
    logic                wr_osc;
    logic                interrupt_priority_enable_reg;
    logic                sw_brownout_enable_reg;
    logic                reset_instruction_flag_reg;
    logic                watchdog_timeout_flag_reg;
    logic                power_down_flag_reg;
    logic                power_on_flag_reg;
    logic                brownout_flag_reg;
    logic                sbor_eff;
    logic [7:0]          rcs_rd;
    logic [2:0]          internal_osc_freq_select_reg;
    logic                primary_clock_ready_flag_reg;
    logic                internal_osc_stable_flag_reg;
    wer_pkg::wer_rkind_e kind_reg;
    wer_pkg::wer_state_e state_reg;
    wer_pkg::wer_src_e   idle_src_reg;
    logic                boot_reg;
    logic [CW-1:0]       cpu_cnt_reg;
    logic [CW-1:0]       osc_cnt_reg;
    logic                osc_act_reg;
    logic                osc_pri_reg;
    logic                osc_int_reg;
    logic                hold_reg;
    logic                exec_reg;
    logic                exec_int_reg;
    logic                shut_reg;
    logic                wdt_clear_reg;
    logic                wdt_rst_reg;
    logic                run_st;
    logic                pm_st;
    logic                wake;
    logic                wdt_rst;
    logic                start;
    logic                osc_done;
    logic                ready_ok;
    logic                shut_now;
    logic                fast;
    logic [CW-1:0]       osc_len;
    logic                hold_c;

    function automatic logic addr_is(input logic [11:0] a,
                                     input logic [11:0] o);
        return a == o;
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_s_n = rst_sync_reg[1];

    // apb decode, zero wait states
    assign acc    = psel & penable;
    assign wr_rcs = acc & pwrite & pstrb[0] & addr_is(paddr, `WER_RCS_OFS);
    assign wr_osc = acc & pwrite & pstrb[0] & addr_is(paddr, `WER_OSC_OFS);
    assign pready  = 1'b1;
    assign pslverr = acc & rd_err;
    assign prdata  = {24'h000000, prdata_reg};

    assign sbor_eff = (brownout_mode_config == `WER_BOR_SW_MODE) ?
                      sw_brownout_enable_reg : 1'b0; // RQ22
    assign rcs_rd = {interrupt_priority_enable_reg, sbor_eff, 1'b0,
                     reset_instruction_flag_reg, watchdog_timeout_flag_reg,
                     power_down_flag_reg, power_on_flag_reg,
                     brownout_flag_reg}; // RQ18

    always_comb begin
        rd_data = 8'h00;
        rd_err  = 1'b0;
        if (addr_is(paddr, `WER_RCS_OFS)) begin
            rd_data = rcs_rd;
        end else if (addr_is(paddr, `WER_OSC_OFS)) begin
            rd_data[`WER_OSC_FREQ_HI:`WER_OSC_FREQ_LO] =
                internal_osc_freq_select_reg;
            rd_data[`WER_OSC_PRI_RDY] = primary_clock_ready_flag_reg;
            rd_data[`WER_OSC_INT_RDY] = internal_osc_stable_flag_reg;
        end else if (addr_is(paddr, `WER_KIND_OFS)) begin
            rd_data[2:0] = kind_reg; // RQ15
        end else begin
            rd_err = 1'b1;
        end
    end

    // read data is captured in the setup phase
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            prdata_reg <= 8'h00;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_reg <= rd_data;
        end
    end

    // reset cause status: software write first, hardware events win
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            interrupt_priority_enable_reg <= 1'b0;
            sw_brownout_enable_reg        <= `WER_SBOR_RST;
            reset_instruction_flag_reg    <= 1'b1;
            watchdog_timeout_flag_reg     <= 1'b1; // RQ19
            power_down_flag_reg           <= 1'b1; // RQ20
            power_on_flag_reg             <= 1'b0; // RQ21
            brownout_flag_reg             <= 1'b0;
        end else begin
            if (wr_rcs) begin // RQ16 RQ17
                interrupt_priority_enable_reg <= pwdata[`WER_RCS_PRIO];
                if (brownout_mode_config == `WER_BOR_SW_MODE) begin
                    sw_brownout_enable_reg <= pwdata[`WER_RCS_SBOR]; // RQ22
                end
                reset_instruction_flag_reg <= pwdata[`WER_RCS_RI];
                power_on_flag_reg          <= pwdata[`WER_RCS_POR];
                brownout_flag_reg          <= pwdata[`WER_RCS_BOR];
            end
            if (watchdog_clear_instruction) begin
                watchdog_timeout_flag_reg <= 1'b1; // RQ19
                power_down_flag_reg       <= 1'b1; // RQ20
            end
            if (sleep_instr) begin
                watchdog_timeout_flag_reg <= 1'b1; // RQ19
                power_down_flag_reg       <= 1'b0; // RQ20
            end
            if (wdt_timeout) begin
                watchdog_timeout_flag_reg <= 1'b0; // RQ19
            end
            if (rst_event) begin // RQ15
                unique case (rst_kind)
                    wer_pkg::WER_RK_POR: begin
                        power_on_flag_reg         <= 1'b0; // RQ21
                        brownout_flag_reg         <= 1'b0;
                        reset_instruction_flag_reg <= 1'b1;
                        watchdog_timeout_flag_reg <= 1'b1; // RQ19
                        power_down_flag_reg       <= 1'b1; // RQ20
                    end
                    wer_pkg::WER_RK_BOR: begin
                        brownout_flag_reg <= 1'b0;
                    end
                    wer_pkg::WER_RK_INSTR: begin
                        reset_instruction_flag_reg <= 1'b0;
                    end
                    wer_pkg::WER_RK_WDT: begin
                        watchdog_timeout_flag_reg <= 1'b0;
                    end
                    wer_pkg::WER_RK_PIN_RUN,
                    wer_pkg::WER_RK_PIN_PM,
                    wer_pkg::WER_RK_STK_FULL,
                    wer_pkg::WER_RK_STK_UNDER: begin
                    end
                endcase
            end
        end
    end

    assign interrupt_priority_enable = interrupt_priority_enable_reg;
    assign bor_enable = (brownout_mode_config == `WER_BOR_SW_MODE) ?
                        sw_brownout_enable_reg :
                        (brownout_mode_config != `WER_BOR_OFF_MODE);

    // internal oscillator frequency select
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            internal_osc_freq_select_reg <= `WER_FREQ_1MHZ; // RQ14
        end else if (wr_osc) begin
            internal_osc_freq_select_reg <=
                pwdata[`WER_OSC_FREQ_HI:`WER_OSC_FREQ_LO];
        end
    end

    // last reset kind
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            kind_reg <= wer_pkg::WER_RK_POR;
        end else if (rst_event) begin
            kind_reg <= rst_kind; // RQ15
        end else if (wdt_rst) begin
            kind_reg <= wer_pkg::WER_RK_WDT; // RQ2
        end
    end

    // watchdog clear and watchdog reset pulses
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            wdt_clear_reg <= 1'b0;
            wdt_rst_reg   <= 1'b0;
        end else begin
            wdt_clear_reg <= sleep_instr | watchdog_clear_instruction |
                             (clock_lost & cfg_failsafe) |
                             (wr_osc & (clk_sel == wer_pkg::WER_SRC_INT));
            wdt_rst_reg   <= wdt_rst; // RQ2
        end
    end
    assign wdt_clear     = wdt_clear_reg; // RQ3
    assign wdt_reset_req = wdt_rst_reg;

    // wake and reset triggers
    assign run_st  = state_reg == wer_pkg::WER_ST_RUN;
    assign pm_st   = (state_reg == wer_pkg::WER_ST_IDLE) |
                     (state_reg == wer_pkg::WER_ST_SLEEP);
    assign wake    = pm_st & (wdt_timeout | rst_event); // RQ1
    assign wdt_rst = run_st & wdt_timeout & ~rst_event; // RQ2
    assign start   = boot_reg | rst_event | wdt_rst | wake;
    assign fast    = cfg_two_speed | cfg_failsafe;

    // exit delay selection from the source before and after wake-up
    always_comb begin
        osc_len = '0;
        if (state_reg == wer_pkg::WER_ST_IDLE &&
            idle_src_reg == wer_pkg::WER_SRC_PRI) begin
            osc_len = '0; // RQ8 RQ10
        end else begin
            unique case (clk_sel)
                wer_pkg::WER_SRC_PRI: begin
                    unique case (cfg_prim_type)
                        wer_pkg::WER_PT_XTAL: osc_len = CW'(OST_CYC); // RQ11
                        wer_pkg::WER_PT_PLL:
                            osc_len = CW'(OST_CYC + PLL_CYC); // RQ11
                        wer_pkg::WER_PT_EXT:  osc_len = '0; // RQ8
                        default:              osc_len = '0;
                    endcase
                end
                wer_pkg::WER_SRC_INT: begin
                    if (state_reg == wer_pkg::WER_ST_IDLE &&
                        idle_src_reg == wer_pkg::WER_SRC_INT) begin
                        osc_len = '0; // RQ12
                    end else begin
                        osc_len = CW'(SETTLE_CYC); // RQ12 RQ23
                    end
                end
                default: osc_len = '0;
            endcase
        end
        // only a primary target holds execution, unless running early
        hold_c = (clk_sel == wer_pkg::WER_SRC_PRI) &
                 (osc_len != '0) & ~fast; // RQ4 RQ6
    end

    assign osc_done = osc_act_reg & (osc_cnt_reg == '0);
    assign ready_ok = (state_reg == wer_pkg::WER_ST_EXIT) &
                      (cpu_cnt_reg == '0) &
                      (~hold_reg | (osc_cnt_reg == '0)); // RQ4 RQ9
    assign shut_now = run_st & sleep_instr & exec_int_reg & osc_act_reg;

    // oscillator delay counter, runs alongside the cpu-ready count
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            osc_cnt_reg <= '0;
            osc_act_reg <= 1'b0;
            osc_pri_reg <= 1'b0;
            osc_int_reg <= 1'b0;
        end else if (start) begin
            osc_cnt_reg <= osc_len; // RQ13 RQ23
            osc_act_reg <= 1'b1;
            osc_pri_reg <= clk_sel == wer_pkg::WER_SRC_PRI;
            osc_int_reg <= clk_sel == wer_pkg::WER_SRC_INT;
        end else if (shut_now) begin
            osc_act_reg <= 1'b0; // RQ7
        end else if (osc_done) begin
            osc_act_reg <= 1'b0;
        end else if (osc_act_reg) begin
            osc_cnt_reg <= osc_cnt_reg - CW'(1);
        end
    end

    // clock ready flags
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            primary_clock_ready_flag_reg <= 1'b0;
            internal_osc_stable_flag_reg <= 1'b0;
        end else begin
            if (start && osc_len != '0) begin
                primary_clock_ready_flag_reg <= 1'b0;
            end
            if (start && clk_sel == wer_pkg::WER_SRC_INT &&
                osc_len != '0) begin
                internal_osc_stable_flag_reg <= 1'b0;
            end
            if (sleep_instr && run_st &&
                !(idle_en && clk_sel == wer_pkg::WER_SRC_PRI)) begin
                primary_clock_ready_flag_reg <= 1'b0; // RQ7
            end
            if (osc_done && osc_pri_reg) begin
                primary_clock_ready_flag_reg <= 1'b1; // RQ4 RQ10
            end
            if (osc_done && osc_int_reg) begin
                internal_osc_stable_flag_reg <= 1'b1; // RQ5 RQ10
            end
        end
    end

    // power-managed state and cpu-ready count
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_reg    <= wer_pkg::WER_ST_RUN;
            idle_src_reg <= wer_pkg::WER_SRC_PRI;
            boot_reg     <= 1'b1;
            cpu_cnt_reg  <= '0;
            hold_reg     <= 1'b0;
            exec_reg     <= 1'b0;
            exec_int_reg <= 1'b0;
            shut_reg     <= 1'b0;
        end else begin
            shut_reg <= shut_now; // RQ7
            boot_reg <= 1'b0;
            if (start) begin
                state_reg    <= wer_pkg::WER_ST_EXIT;
                cpu_cnt_reg  <= pm_st ? CW'(CPU_CYC) : '0; // RQ9 RQ13
                hold_reg     <= hold_c; // RQ4
                exec_reg     <= 1'b0;
                exec_int_reg <= hold_c ? 1'b0 : fast &
                                (clk_sel == wer_pkg::WER_SRC_PRI) &
                                (osc_len != '0); // RQ6
            end else begin
                unique case (state_reg)
                    wer_pkg::WER_ST_RUN: begin
                        if (sleep_instr) begin
                            state_reg    <= idle_en ?
                                wer_pkg::WER_ST_IDLE : wer_pkg::WER_ST_SLEEP;
                            idle_src_reg <= clk_sel;
                            exec_reg     <= 1'b0;
                        end
                        if (shut_now) begin
                            exec_int_reg <= 1'b0; // RQ7
                        end else if (osc_done && osc_pri_reg) begin
                            exec_int_reg <= 1'b0; // RQ7
                        end
                    end
                    wer_pkg::WER_ST_IDLE,
                    wer_pkg::WER_ST_SLEEP: begin
                        exec_reg <= 1'b0;
                    end
                    wer_pkg::WER_ST_EXIT: begin
                        if (cpu_cnt_reg != '0) begin
                            cpu_cnt_reg <= cpu_cnt_reg - CW'(1);
                        end
                        if (ready_ok) begin
                            state_reg <= wer_pkg::WER_ST_RUN;
                            exec_reg  <= 1'b1; // RQ9
                        end
                    end
                endcase
            end
        end
    end

    assign cpu_exec         = exec_reg;
    assign exec_internal    = exec_int_reg;
    assign primary_shutdown = shut_reg;

    // checks
    wdt_pm_wake_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pm_st && wdt_timeout |=> !wdt_reset_req &&
        state_reg == wer_pkg::WER_ST_EXIT) // RQ1
        else $error("watchdog time-out in power-managed mode reset");

    wdt_run_rst_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        run_st && wdt_timeout && !rst_event |=> wdt_reset_req &&
        kind_reg == wer_pkg::WER_RK_WDT) // RQ2
        else $error("watchdog time-out while running gave no reset");

    wdt_clear_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        sleep_instr || watchdog_clear_instruction |=> wdt_clear) // RQ3
        else $error("watchdog not cleared");

    exit_hold_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        $rose(exec_reg) |-> $past(ready_ok)) // RQ4
        else $error("execution started before exit delay ended");

    cpu_delay_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        wake |=> (!cpu_exec) [*2]) // RQ9
        else $error("execution resumed without cpu-ready delay");

    to_flag_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        wdt_timeout |=> !watchdog_timeout_flag_reg) // RQ19
        else $error("time-out flag not cleared by watchdog time-out");

    pd_flag_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        sleep_instr && !watchdog_clear_instruction && !rst_event
        |=> !power_down_flag_reg) // RQ20
        else $error("power-down flag not cleared by sleep");

    por_flag_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        rst_event && rst_kind == wer_pkg::WER_RK_POR
        |=> !power_on_flag_reg) // RQ21
        else $error("power-on flag not cleared on power-on reset");

    sbor_read_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        brownout_mode_config != `WER_BOR_SW_MODE |-> !rcs_rd[6]) // RQ22
        else $error("brown-out enable bit visible outside mode 01");

    shutdown_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        shut_now |=> primary_shutdown && !osc_act_reg) // RQ7
        else $error("primary not shut down on early sleep");

endmodule

// ---- dv/wer_wdog.sv ----
// watchdog model that times out unless the block clears it
`timescale 1ns/1ps
module wer_wdog #(
    parameter int LIMIT = 40
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // enable, clear and time-out
    input  wire logic en,
    input  wire logic clr,
    output logic      timeout
);
    int cnt_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 0;
            timeout <= 1'b0;
        end else begin
            timeout <= en && !clr && cnt_reg == LIMIT - 1;
            // a clear from the block restarts the count
            if (clr || !en || cnt_reg == LIMIT - 1) begin
                cnt_reg <= 0;
            end else begin
                cnt_reg <= cnt_reg + 1;
            end
        end
    end
endmodule

// ---- dv/wake_exit_and_reset_status_test.sv ----
// self-checking bench for the wake exit and reset status block
`timescale 1ns/1ps
module wake_exit_and_reset_status_test;
    localparam int CPU = 4;
    logic                mclk, rst_n, psel, penable, pwrite, pready, se;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, q;
    logic [3:0]          pstrb, ev, mon;
    logic [1:0]          brownout_mode_config;
    logic                cfg_two_speed, cfg_failsafe, idle_en, wd_en, exi;
    logic                wdt_timeout, wdt_clear, wdt_reset_req, cpu_exec;
    logic                bor_enable, interrupt_priority_enable, pslverr;
    wer_pkg::wer_ptype_e cfg_prim_type;
    wer_pkg::wer_src_e   clk_sel;
    wer_pkg::wer_rkind_e rst_kind;
    int                  err_total, comparisons, n;
    int                  rr_cnt = 0;
    assign mon = {wdt_reset_req, wdt_timeout, wdt_clear, cpu_exec};
    wer_top #(.OST_CYC(4), .PLL_CYC(4), .CPU_CYC(CPU),
              .SETTLE_CYC(4)) u_wer_top (
        .mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .brownout_mode_config, .cfg_two_speed,
        .cfg_failsafe, .cfg_prim_type, .sleep_instr(ev[0]), .idle_en,
        .watchdog_clear_instruction(ev[1]), .clk_sel, .wdt_timeout,
        .clock_lost(ev[2]), .rst_event(ev[3]), .rst_kind, .wdt_clear,
        .wdt_reset_req, .cpu_exec, .exec_internal(exi), .primary_shutdown(),
        .bor_enable, .interrupt_priority_enable);
    wer_wdog #(.LIMIT(40)) u_wer_wdog (
        .mclk, .rst_n, .en(wd_en), .clr(wdt_clear), .timeout(wdt_timeout));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (wdt_reset_req === 1'b1) rr_cnt++;
    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 50);
        q = prdata;
        se = pslverr;
        if (k >= 50) begin err_total++; end_of_test(); end
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read data", e, q);
    endtask
    task automatic wt(input int b);
        n = 0;
        // look once before the next edge so a one-cycle pulse is not missed
        #1;
        while (mon[b] !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 3000) begin err_total++; end_of_test(); end
    endtask
    task automatic pulse(input int b);
        @(posedge mclk) ev[b] <= 1'b1;
        @(posedge mclk) ev[b] <= 1'b0;
    endtask
    task automatic reg_access();
        rd(12'h000, 32'h5C);
        apb(1'b0, 12'h004, 32'h0);
        chk("frequency", 32'h4, {29'h0, q[6:4]});
        apb(1'b1, 12'h000, 32'hFF);
        rd(12'h000, 32'hDF);
        chk("priority", 32'h1, interrupt_priority_enable);
        chk("brownout enable", 32'h1, bor_enable);
        @(posedge mclk) brownout_mode_config <= 2'h2;
        rd(12'h000, 32'h9F);
        @(posedge mclk) brownout_mode_config <= 2'h1;
        apb(1'b1, 12'h000, 32'h13);
        rd(12'h000, 32'h1F);
        apb(1'b0, 12'h0C0, 32'h0);
        chk("slave error", 32'h1, se);
    endtask
    task automatic idle_wake();
        pulse(0);
        wt(1);
        rd(12'h000, 32'h1B);
        @(posedge mclk) wd_en <= 1'b1;
        wt(2);
        wt(0);
        chk("exit delay", 32'h1, {31'h0, n >= CPU && n <= CPU + 3});
        chk("reset requests", 32'h0, rr_cnt);
        @(posedge mclk) wd_en <= 1'b0;
        rd(12'h000, 32'h13);
    endtask
    task automatic run_timeout();
        @(posedge mclk) wd_en <= 1'b1;
        wt(3);
        @(posedge mclk) wd_en <= 1'b0;
        pulse(1);
        wt(1);
        rd(12'h000, 32'h1F);
        chk("reset requests", 32'h1, rr_cnt);
        @(posedge mclk) cfg_failsafe <= 1'b1;
        pulse(2);
        wt(1);
        pulse(3);
        apb(1'b0, 12'h000, 32'h0);
        chk("power-on flag", 32'h10, q & 32'h12);
        @(posedge mclk) begin
            cfg_prim_type <= wer_pkg::WER_PT_XTAL;
            rst_kind      <= wer_pkg::WER_RK_INSTR;
        end
        pulse(3);
        #1 chk("internal run", 32'h1, exi);
        repeat (6) @(posedge mclk);
        rd(12'h004, 32'h48);
        chk("internal run", 32'h0, exi);
        rd(12'h008, 32'h5);
        rd(12'h000, 32'h0C);
    endtask
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hF; ev = 4'h0; wd_en = 1'b0;
        brownout_mode_config = 2'h1; cfg_two_speed = 1'b0; cfg_failsafe = 1'b0;
        idle_en = 1'b1; cfg_prim_type = wer_pkg::WER_PT_EXT;
        clk_sel = wer_pkg::WER_SRC_PRI; rst_kind = wer_pkg::WER_RK_POR;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        wt(0);
        reg_access();
        idle_wake();
        run_timeout();
        end_of_test();
    end
endmodule
